// *** shared/charger_control_pkg.sv ***
// shared constants and types for the third charger control word
package charger_control_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0]  REG_OFFSET      = 8'h4C;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic [6:0]  SLAVE_ADDR      = 7'h2A;
	localparam logic [15:0] STRAP_MASK      = 16'h0080;

	// field positions
	localparam int B_NO_REREAD   = 15;
	localparam int B_NO_RELOAD   = 14;
	localparam int B_TERM_LONG   = 13;
	localparam int B_TMO_HI      = 12;
	localparam int B_TMO_LO      = 11;
	localparam int B_FET_OFF     = 10;
	localparam int B_PWR_GAIN    = 9;
	localparam int B_DIODE_EXIT  = 8;
	localparam int B_HOST_MODE   = 7;
	localparam int B_FB_HALF     = 6;
	localparam int B_LOOP_OFF    = 5;
	localparam int B_ABSENT_OFF  = 4;
	localparam int B_MON_REV     = 3;
	localparam int B_DIG_RESET   = 2;
	localparam int B_STRETCH     = 1;
	localparam int B_STARTUP     = 0;

	// ************************************************
	// timing
	// ************************************************
	localparam int CLOCK_KHZ     = 20000;
	localparam int TICK_US       = 500;
	localparam int TICK_CYCLES   = TICK_US * CLOCK_KHZ / 1000;
	localparam int TW            = 20;

	localparam int TERM_SHORT_US = 20000;
	localparam int TERM_LONG_US  = 200000;
	localparam int TMO_0_US      = 175000000;
	localparam int TMO_1_US      = 87500000;
	localparam int TMO_2_US      = 43750000;
	localparam int TMO_3_US      = 5000000;
	localparam int DIODE_0_US    = 40000;
	localparam int DIODE_1_US    = 5000;
	localparam int DIODE_2_US    = 80000;
	localparam int DIODE_3_US    = 1000;
	localparam int START_0_US    = 1300000;
	localparam int START_2_US    = 150000;
	localparam int START_3_US    = 7500;

	localparam logic [TW-1:0] TERM_SHORT_T = TW'(TERM_SHORT_US / TICK_US);
	localparam logic [TW-1:0] TERM_LONG_T  = TW'(TERM_LONG_US / TICK_US);
	localparam logic [TW-1:0] TMO_0_T      = TW'(TMO_0_US / TICK_US);
	localparam logic [TW-1:0] TMO_1_T      = TW'(TMO_1_US / TICK_US);
	localparam logic [TW-1:0] TMO_2_T      = TW'(TMO_2_US / TICK_US);
	localparam logic [TW-1:0] TMO_3_T      = TW'(TMO_3_US / TICK_US);
	localparam logic [TW-1:0] DIODE_0_T    = TW'(DIODE_0_US / TICK_US);
	localparam logic [TW-1:0] DIODE_1_T    = TW'(DIODE_1_US / TICK_US);
	localparam logic [TW-1:0] DIODE_2_T    = TW'(DIODE_2_US / TICK_US);
	localparam logic [TW-1:0] DIODE_3_T    = TW'(DIODE_3_US / TICK_US);
	localparam logic [TW-1:0] START_0_T    = TW'(START_0_US / TICK_US);
	localparam logic [TW-1:0] START_2_T    = TW'(START_2_US / TICK_US);
	localparam logic [TW-1:0] START_3_T    = TW'(START_3_US / TICK_US);

	// ************************************************
	// serial engine
	// ************************************************
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_ADDR   = 8'h02,
		ST_CMD    = 8'h04,
		ST_WLO    = 8'h08,
		ST_WHI    = 8'h10,
		ST_RLO    = 8'h20,
		ST_RHI    = 8'h40,
		ST_IGNORE = 8'h80
	} bus_state_e;

endpackage

// *** logic/interval_timer.sv ***
// tick-driven interval timer with saturating count and expiry flag
`timescale 1ns/1ps
module interval_timer
	import charger_control_pkg::*;
(
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          reset_n_i,
	// control
	input  wire logic          tick_i,
	input  wire logic          run_i,
	input  wire logic [TW-1:0] limit_i,
	// status
	output logic               expired_o
);

	logic [TW-1:0] count_q;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_q <= '0;
		end else if (!run_i) begin
			count_q <= '0;
		end else if (tick_i && count_q < limit_i) begin
			count_q <= count_q + TW'(1);
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			expired_o <= 1'b0;
		end else begin
			expired_o <= run_i && count_q >= limit_i;
		end
	end

endmodule

// *** logic/charger_control_word_three.sv ***
// third charger control word with its serial bus slave and timers
// How it works
// - bit 15 zero requests strap reread on adapter insertion; one suppresses it
// - bit 14 zero reloads input limit one on adapter insertion; one leaves it
// - bit 13 picks termination time: 20 ms or 200 ms
// - bits 12:11 pick charger timeout 175, 87.5, 43.75 or 5 s
// - bit 10 one forces the battery FET gate off
// - bit 9 one halves the system power monitor gain
// - bit 8 with seventh word bit 7 picks diode exit 40/5/80/1 ms
// - bit 7 zero autonomous, one host charge control; reset value from strap
// - bit 6 one halves the current feedback gain
// - bit 5 one disables input current limit loops both directions
// - bit 4 one disables forward input loop while battery absent
// - bit 3 one monitors reverse output and discharge current
// - writing one to bit 2 returns all registers to defaults
// - bit 1 with fourth word bit 8 picks stretch 0.6x/1x/3x/2x
// - bit 0 with second word bit 13 picks start-up 1.3 s/150/7.5 ms
`timescale 1ns/1ps
module charger_control_word_three
	import charger_control_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	// serial bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// system inputs
	input  wire logic       strap_host_mode_i,
	input  wire logic       adapter_insert_i,
	input  wire logic       battery_absent_flag_i,
	input  wire logic       charge_write_i,
	input  wire logic       term_condition_i,
	input  wire logic       low_discharge_i,
	input  wire logic       reverse_request_i,
	input  wire logic       seventh_control_word_b7_i,
	input  wire logic       fourth_control_word_b8_i,
	input  wire logic       second_control_word_b13_i,
	// control outputs
	output logic            strap_reread_o,
	output logic            reload_limit_o,
	output logic            battery_fet_gate_off_o,
	output logic            power_gain_half_o,
	output logic            host_charge_mode_o,
	output logic            feedback_gain_half_o,
	output logic            fwd_loop_en_o,
	output logic            rev_loop_en_o,
	output logic            monitor_reverse_o,
	output logic [1:0]      stretch_code_o,
	output logic            digital_reset_o,
	// timer outputs
	output logic            charger_timeout_o,
	output logic            term_done_o,
	output logic            diode_exit_o,
	output logic            reverse_ready_o
);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	// ************************************************
	// register and strap capture
	// ************************************************
	logic [15:0]    reg_q;
	logic           strap_loaded_q;
	logic           write_go;
	logic [15:0]    write_data;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_loaded_q <= 1'b0;
		end else if (write_go && write_data[B_DIG_RESET]) begin
			strap_loaded_q <= 1'b0;
		end else begin
			strap_loaded_q <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_q <= REG_RESET;
		end else if (!strap_loaded_q) begin
			reg_q <= REG_RESET | (strap_host_mode_i ? STRAP_MASK : 16'h0000);
		end else if (write_go && write_data[B_DIG_RESET]) begin
			reg_q <= REG_RESET;
		end else if (write_go) begin
			reg_q <= write_data & ~(16'h0001 << B_DIG_RESET);
		end
	end

	a_reset_bit_zero: assert property (reg_q[B_DIG_RESET] == 1'b0)
		else $error("reset bit stored as one");

	a_strap_mode: assert property ($rose(strap_loaded_q) |->
		reg_q[B_HOST_MODE] == $past(strap_host_mode_i))
		else $error("mode bit not taken from strap");

	a_dig_reset: assert property (write_go && write_data[B_DIG_RESET] |=>
		(reg_q & ~STRAP_MASK) == REG_RESET && digital_reset_o)
		else $error("digital reset left a field set");

	// ************************************************
	// serial bus slave
	// ************************************************
	bus_state_e     state_q;
	logic           scl_q;
	logic           sda_q;
	logic [3:0]     bit_q;
	logic           ack_q;
	logic [7:0]     shift_q;
	logic [7:0]     cmd_q;
	logic [7:0]     lo_q;
	logic [15:0]    read_word;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_seen;
	logic           stop_seen;

	assign scl_rise   = scl_i && !scl_q;
	assign scl_fall   = !scl_i && scl_q;
	assign start_seen = scl_i && scl_q && sda_q && !sda_i;
	assign stop_seen  = scl_i && scl_q && !sda_q && sda_i;
	assign read_word  = (cmd_q == REG_OFFSET) ? reg_q : 16'h0000;
	assign write_go   = state_q == ST_WHI && scl_fall && bit_q == BITS_PER_BYTE && !ack_q
		&& cmd_q == REG_OFFSET;
	assign write_data = {shift_q, lo_q};

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_o <= 1'b0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			sda_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q  <= ST_IDLE;
			bit_q    <= '0;
			ack_q    <= 1'b0;
			shift_q  <= '0;
			cmd_q    <= '0;
			lo_q     <= '0;
			sda_oe_o <= 1'b0;
		end else if (start_seen) begin
			state_q  <= ST_ADDR;
			bit_q    <= '0;
			ack_q    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (stop_seen) begin
			state_q  <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_CMD, ST_WLO, ST_WHI: begin
					if (scl_rise && bit_q < BITS_PER_BYTE) begin
						shift_q <= {shift_q[6:0], sda_i};
						bit_q   <= bit_q + 4'h1;
					end else if (scl_fall && bit_q == BITS_PER_BYTE && !ack_q) begin
						if (state_q == ST_ADDR && shift_q[7:1] != SLAVE_ADDR) begin
							state_q <= ST_IGNORE;
						end else begin
							ack_q    <= 1'b1;
							sda_oe_o <= 1'b1;
							if (state_q == ST_CMD) begin
								cmd_q <= shift_q;
							end else if (state_q == ST_WLO) begin
								lo_q <= shift_q;
							end
						end
					end else if (scl_fall && ack_q) begin
						ack_q    <= 1'b0;
						bit_q    <= '0;
						sda_oe_o <= 1'b0;
						if (state_q == ST_ADDR && shift_q[0]) begin
							state_q  <= ST_RLO;
							shift_q  <= read_word[7:0];
							sda_oe_o <= !read_word[7];
						end else if (state_q == ST_ADDR) begin
							state_q <= ST_CMD;
						end else if (state_q == ST_CMD) begin
							state_q <= ST_WLO;
						end else if (state_q == ST_WLO) begin
							state_q <= ST_WHI;
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_RLO, ST_RHI: begin
					if (scl_rise && bit_q < BITS_PER_BYTE) begin
						bit_q <= bit_q + 4'h1;
					end else if (scl_rise && ack_q && sda_i) begin
						state_q <= ST_IGNORE;
					end else if (scl_fall && bit_q < BITS_PER_BYTE) begin
						shift_q  <= {shift_q[6:0], 1'b0};
						sda_oe_o <= !shift_q[6];
					end else if (scl_fall && !ack_q) begin
						ack_q    <= 1'b1;
						sda_oe_o <= 1'b0;
					end else if (scl_fall && ack_q && state_q == ST_RLO) begin
						ack_q    <= 1'b0;
						bit_q    <= '0;
						state_q  <= ST_RHI;
						shift_q  <= read_word[15:8];
						sda_oe_o <= !read_word[15];
					end else if (scl_fall && ack_q) begin
						state_q <= ST_IGNORE;
					end
				end
				default: begin
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end

	a_idle_quiet: assert property (state_q == ST_IGNORE || state_q == ST_IDLE |=> !sda_oe_o)
		else $error("data line driven while idle");

	// ************************************************
	// tick divider and timers
	// ************************************************
	logic [15:0]    div_q;
	logic           tick_q;
	logic [TW-1:0]  term_limit;
	logic [TW-1:0]  tmo_limit;
	logic [TW-1:0]  diode_limit;
	logic [TW-1:0]  start_limit;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == 16'(TICK_LEN - 1);
			div_q  <= (div_q == 16'(TICK_LEN - 1)) ? 16'h0000 : div_q + 16'h0001;
		end
	end

	always_comb begin
		term_limit = reg_q[B_TERM_LONG] ? TERM_LONG_T : TERM_SHORT_T;
		case (reg_q[B_TMO_HI:B_TMO_LO])
			2'b00:   tmo_limit = TMO_0_T;
			2'b01:   tmo_limit = TMO_1_T;
			2'b10:   tmo_limit = TMO_2_T;
			default: tmo_limit = TMO_3_T;
		endcase
		case ({reg_q[B_DIODE_EXIT], seventh_control_word_b7_i})
			2'b00:   diode_limit = DIODE_0_T;
			2'b01:   diode_limit = DIODE_1_T;
			2'b10:   diode_limit = DIODE_2_T;
			default: diode_limit = DIODE_3_T;
		endcase
		case ({second_control_word_b13_i, reg_q[B_STARTUP]})
			2'b10:   start_limit = START_2_T;
			2'b11:   start_limit = START_3_T;
			default: start_limit = START_0_T;
		endcase
	end

	a_term_select: assert property (term_limit ==
		(reg_q[B_TERM_LONG] ? TW'(400) : TW'(40)))
		else $error("termination time wrong");

	a_timeout_select: assert property (reg_q[B_TMO_HI:B_TMO_LO] == 2'b11 |->
		tmo_limit == TW'(10000))
		else $error("short charger timeout wrong");

	a_diode_select: assert property (reg_q[B_DIODE_EXIT] && seventh_control_word_b7_i |->
		diode_limit == TW'(2))
		else $error("diode exit time wrong");

	a_start_select: assert property (second_control_word_b13_i && reg_q[B_STARTUP] |->
		start_limit == TW'(15))
		else $error("start-up delay wrong");

	interval_timer u_timeout (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_q),
		.run_i     (reg_q[B_HOST_MODE] && !charge_write_i),
		.limit_i   (tmo_limit),
		.expired_o (charger_timeout_o)
	);

	interval_timer u_term (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_q),
		.run_i     (!reg_q[B_HOST_MODE] && term_condition_i),
		.limit_i   (term_limit),
		.expired_o (term_done_o)
	);

	interval_timer u_diode (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_q),
		.run_i     (low_discharge_i),
		.limit_i   (diode_limit),
		.expired_o (diode_exit_o)
	);

	interval_timer u_start (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_q),
		.run_i     (reverse_request_i),
		.limit_i   (start_limit),
		.expired_o (reverse_ready_o)
	);

	// ************************************************
	// registered control outputs
	// ************************************************
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_reread_o         <= 1'b0;
			reload_limit_o         <= 1'b0;
			battery_fet_gate_off_o <= 1'b0;
			power_gain_half_o      <= 1'b0;
			host_charge_mode_o     <= 1'b0;
			feedback_gain_half_o   <= 1'b0;
			fwd_loop_en_o          <= 1'b0;
			rev_loop_en_o          <= 1'b0;
			monitor_reverse_o      <= 1'b0;
			stretch_code_o         <= 2'b00;
			digital_reset_o        <= 1'b0;
		end else begin
			strap_reread_o         <= adapter_insert_i && !reg_q[B_NO_REREAD];
			reload_limit_o         <= adapter_insert_i && !reg_q[B_NO_RELOAD];
			battery_fet_gate_off_o <= reg_q[B_FET_OFF];
			power_gain_half_o      <= reg_q[B_PWR_GAIN];
			host_charge_mode_o     <= reg_q[B_HOST_MODE];
			feedback_gain_half_o   <= reg_q[B_FB_HALF];
			rev_loop_en_o          <= !reg_q[B_LOOP_OFF];
			fwd_loop_en_o          <= !reg_q[B_LOOP_OFF] &&
				!(reg_q[B_ABSENT_OFF] && battery_absent_flag_i);
			monitor_reverse_o      <= reg_q[B_MON_REV];
			stretch_code_o         <= {reg_q[B_STRETCH], fourth_control_word_b8_i};
			digital_reset_o        <= write_go && write_data[B_DIG_RESET];
		end
	end

	a_reread_gate: assert property (adapter_insert_i |=>
		strap_reread_o == !$past(reg_q[B_NO_REREAD]))
		else $error("strap reread wrong");

	a_reload_gate: assert property (adapter_insert_i |=>
		reload_limit_o == !$past(reg_q[B_NO_RELOAD]))
		else $error("limit reload wrong");

	a_fet_gain: assert property (##1 battery_fet_gate_off_o == $past(reg_q[B_FET_OFF]) &&
		power_gain_half_o == $past(reg_q[B_PWR_GAIN]) &&
		feedback_gain_half_o == $past(reg_q[B_FB_HALF]) &&
		monitor_reverse_o == $past(reg_q[B_MON_REV]))
		else $error("direct field output lags");

	a_loop_enables: assert property (reg_q[B_ABSENT_OFF] && !reg_q[B_LOOP_OFF]
		&& battery_absent_flag_i |=> !fwd_loop_en_o && rev_loop_en_o)
		else $error("absent loop gating wrong");

	a_loops_off: assert property (reg_q[B_LOOP_OFF] |=> !fwd_loop_en_o && !rev_loop_en_o)
		else $error("input loops still enabled");

	a_stretch_code: assert property (##1 stretch_code_o ==
		{$past(reg_q[B_STRETCH]), $past(fourth_control_word_b8_i)})
		else $error("stretch code wrong");

endmodule

// *** verif/smbus_host_model.sv ***
// bus host model driving the serial clock and pulling the data line low
`timescale 1ns/1ps
module smbus_host_model
	import charger_control_pkg::*;
(
	// clock
	input  wire logic clock_i,
	// bus pins
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end

	// ************************************************
	// bus phases
	// ************************************************
	task automatic half();
		repeat (5) @(posedge clock_i);
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_low_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_low_o <= 1'b1;
		half();
		scl_o <= 1'b0;
		half();
	endtask

	task automatic stop();
		sda_low_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_low_o <= 1'b0;
		half();
	endtask

	// nine clocks: a one in tx releases the line, rx holds what the wire showed
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low_o <= !tx[i];
			half();
			scl_o <= 1'b1;
			half();
			rx[i] = sda_i;
			scl_o <= 1'b0;
			half();
		end
	endtask

	// ************************************************
	// word transfers
	// ************************************************
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] val, output logic ok);
		logic [8:0] r0, r1, r2, r3;
		start();
		xfer({SLAVE_ADDR, 1'b0, 1'b1}, r0);
		xfer({cmd, 1'b1}, r1);
		xfer({val[7:0], 1'b1}, r2);
		xfer({val[15:8], 1'b1}, r3);
		stop();
		ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
	endtask

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] val);
		logic [8:0] r0, r1, r2, r3, r4;
		start();
		xfer({SLAVE_ADDR, 1'b0, 1'b1}, r0);
		xfer({cmd, 1'b1}, r1);
		start();
		xfer({SLAVE_ADDR, 1'b1, 1'b1}, r2);
		xfer({8'hFF, 1'b0}, r3);
		xfer({8'hFF, 1'b1}, r4);
		stop();
		val = {r4[8:1], r3[8:1]};
	endtask
endmodule

// *** verif/test_charger_control_word_three.sv ***
// self-checking bench for the third charger control word
`timescale 1ns/1ps
module test_charger_control_word_three;
	import charger_control_pkg::*;
	localparam int TL = 10;

	logic        clock_i, reset_n_i, scl, host_low, sda_o, sda_oe;
	logic        strap, adapter, absent, chg_wr, term, low_dis, rev;
	logic        s7, f4, s13, reread, reload, fet, pwr, host_m, fb;
	logic        fwd, rvl, mon, dig, tmo, term_done, dexit, rdy;
	logic [1:0]  stretch;
	int          num_errors, checks_done;
	int          pulses = 0;
	wire logic   sda = !(host_low || (sda_oe && !sda_o));
	wire logic [15:0] outs = {7'h00, fet, pwr, host_m, fb, mon, rvl, fwd, stretch};

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		{reset_n_i, strap, adapter, absent, chg_wr, term} = '0;
		{low_dis, rev, s7, f4, s13} = '0;
	end
	always @(posedge clock_i) if (dig === 1'b1) pulses++;

	smbus_host_model host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

	charger_control_word_three #(.TICK_LEN(TL)) DUT (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .strap_host_mode_i(strap),
		.adapter_insert_i(adapter), .battery_absent_flag_i(absent),
		.charge_write_i(chg_wr), .term_condition_i(term), .low_discharge_i(low_dis),
		.reverse_request_i(rev), .seventh_control_word_b7_i(s7),
		.fourth_control_word_b8_i(f4), .second_control_word_b13_i(s13),
		.strap_reread_o(reread), .reload_limit_o(reload), .battery_fet_gate_off_o(fet),
		.power_gain_half_o(pwr), .host_charge_mode_o(host_m), .feedback_gain_half_o(fb),
		.fwd_loop_en_o(fwd), .rev_loop_en_o(rvl), .monitor_reverse_o(mon),
		.stretch_code_o(stretch), .digital_reset_o(dig), .charger_timeout_o(tmo),
		.term_done_o(term_done), .diode_exit_o(dexit), .reverse_ready_o(rdy)
	);

	// ************************************************
	// helpers
	// ************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	function automatic logic [15:0] exp_out(input logic [15:0] v, input logic ab, input logic f);
		return {7'h00, v[10], v[9], v[7], v[6], v[3], !v[5], !v[5] && !(v[4] && ab), v[1], f};
	endfunction

	function automatic logic tmr(input int s);
		return (s == 0) ? term_done : (s == 1) ? dexit : rdy;
	endfunction

	task automatic do_reset(input logic st);
		strap <= st;
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
		logic ok;
		host.write_word(cmd, v, ok);
		check({15'h0000, ok}, 16'h0001, "ack");
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
		logic [15:0] v;
		host.read_word(cmd, v);
		check(v, e, "read");
	endtask

	task automatic time_it(input int sel, input int ticks);
		int n;
		n = 0;
		while (tmr(sel) !== 1'b1 && n < (ticks + 3) * TL) begin
			@(posedge clock_i);
			n++;
		end
		check(16'(n >= (ticks - 1) * TL && tmr(sel) === 1'b1), 16'h0001, "timer");
		if (n >= (ticks + 3) * TL) final_report();
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset();
		do_reset(1'b1);
		rd(REG_OFFSET, STRAP_MASK);
		check(outs, exp_out(STRAP_MASK, 1'b0, 1'b0), "strap");
		do_reset(1'b0);
		rd(REG_OFFSET, REG_RESET);
		check(outs, exp_out(REG_RESET, 1'b0, 1'b0), "defaults");
	endtask

	task automatic t_fields();
		logic [15:0] v;
		for (int b = 0; b < 16; b++) begin
			v = 16'h0001 << b;
			wr(REG_OFFSET, v);
			rd(REG_OFFSET, (b == 2) ? 16'h0000 : v);
			for (int k = 0; k < 2; k++) begin
				absent <= k[0];
				f4 <= !k[0];
				repeat (3) @(posedge clock_i);
				check(outs, exp_out(v, k[0], !k[0]), "pins");
			end
		end
	endtask

	task automatic t_insert();
		logic [1:0] i;
		for (int j = 0; j < 4; j++) begin
			i = j[1:0];
			wr(REG_OFFSET, {i, 14'h0000});
			adapter <= 1'b1;
			@(posedge clock_i);
			adapter <= 1'b0;
			@(posedge clock_i);
			check({14'h0000, reread, reload}, {14'h0000, ~i}, "insert");
		end
	endtask

	task automatic t_dig_reset();
		int p;
		strap <= 1'b1;
		wr(REG_OFFSET, 16'h8A6A);
		p = pulses;
		wr(REG_OFFSET, 16'h0004);
		check(16'(pulses - p), 16'h0001, "reset pulse");
		rd(REG_OFFSET, STRAP_MASK);
		check(outs, exp_out(STRAP_MASK, absent, f4), "after reset");
		wr(8'h3D, 16'hFFFF);
		rd(REG_OFFSET, STRAP_MASK);
	endtask

	task automatic t_timers();
		int dt[4] = '{80, 10, 160, 2};
		int st[4] = '{2600, 2600, 300, 15};
		logic [1:0] c;
		for (int j = 0; j < 2; j++) begin
			term <= 1'b0;
			wr(REG_OFFSET, {2'h0, j[0], 13'h0000});
			term <= 1'b1;
			time_it(0, (j == 0) ? 40 : 400);
		end
		term <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			c = j[1:0];
			wr(REG_OFFSET, {7'h00, c[1], 8'h00});
			s7 <= c[0];
			low_dis <= 1'b1;
			time_it(1, dt[j]);
			low_dis <= 1'b0;
		end
		for (int j = 1; j < 4; j++) begin
			c = j[1:0];
			s13 <= c[1];
			wr(REG_OFFSET, {15'h0000, c[0]});
			rev <= 1'b1;
			time_it(2, st[j]);
			rev <= 1'b0;
		end
		// host mode, shortest timeout: far from expiry after a charge write
		wr(REG_OFFSET, 16'h1880);
		chg_wr <= 1'b1;
		repeat (3) @(posedge clock_i);
		chg_wr <= 1'b0;
		repeat (20 * TL) @(posedge clock_i);
		check({15'h0000, tmo}, 16'h0000, "timeout early");
	endtask

	initial begin
		num_errors = 0;
		checks_done = 0;
		t_reset();
		t_fields();
		t_insert();
		t_dig_reset();
		strap <= 1'b0;
		t_timers();
		final_report();
	end
endmodule
